// >>> verilog/wwrf_top.sv
// Summary of operation
// - scan-chain reset sets status bit 4; power-on or written zero clears it.
// - watchdog reset sets status bit 3; power-on or written zero clears it.
// - brown-out reset sets status bit 2; power-on or written zero clears it.
// - pin reset sets status bit 1; power-on or written zero clears it.
// - power-on sets status bit 0; only a written zero clears it.
// - time-out in interrupt operation sets bit 7; vector or written one clears.
// - interrupt request needs flag, enable bit 6 and cpu global enable.
// - combined mode vector taken clears enable and flag, leaving reset mode.
// - combined mode, unserviced flag at next time-out gives system reset.
// - unprogrammed always-on: reset/irq enables select stop, irq, reset, both.
// - programmed always-on forces system reset on every time-out.
// - clear reset enable or change prescaler only in four-cycle unlock window.
// - reset enable reads one while the watchdog cause bit is set.
// - prescaler 2048 cycles doubling per code to 1048576; codes above reserved.
// - status register at data offset 0x54 and io offset 0x34.
// - control register at 0x60, data space only.
// - count watchdog oscillator cycles, act when time-out reached.
// - kick restarts the counter from zero.
// - programmed always-on holds reset enable one and irq enable zero.
`default_nettype none
module wwrf_top #(
  parameter int BASE_CYCLES = 2048
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_io_space,
  input wire logic cpu_we,
  input wire logic cpu_re,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic cpu_global_irq_en,
  input wire logic dog_vector_taken,
  input wire logic dog_kick,
  input wire logic always_on_setting,
  input wire logic wdt_osc,
  input wire logic pin_reset_event,
  input wire logic brownout_event,
  input wire logic scan_reset_event,
  output logic dog_irq_req,
  output logic dog_sys_reset
);

  logic [4:0] status_reg, status_next;
  logic irq_flag_reg, irq_flag_next;
  logic irq_en_reg, irq_en_next;
  logic rst_en_reg, rst_en_next;
  logic [3:0] tsel_reg, tsel_next;
  logic [2:0] unlock_reg, unlock_next;
  logic [wwrf_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic sys_rst_reg, sys_rst_next;
  logic [7:0] rdata_reg, rdata_next;

  logic forced, rst_en_eff, irq_en_eff, unlocked, tick, timeout;
  logic wr_status, wr_ctrl, rd_status, rd_ctrl, any_reset;
  logic [7:0] ctrl_view;

  // time-out length in oscillator cycles; reserved codes take the longest
  function automatic logic [wwrf_pkg::CNT_W-1:0] tmo_limit(
      input logic [3:0] code);
    logic [wwrf_pkg::CNT_W-1:0] base;
    base = wwrf_pkg::CNT_W'(BASE_CYCLES);
    if (code > wwrf_pkg::TSEL_LAST) begin
      tmo_limit = base << wwrf_pkg::TSEL_LAST;
    end else begin
      tmo_limit = base << code;
    end
  endfunction

  function automatic logic status_hit(input logic [15:0] a,
                                      input logic io);
    status_hit = io ? (a == wwrf_pkg::STATUS_IO_ADDR)
                    : (a == wwrf_pkg::STATUS_DATA_ADDR);
  endfunction

  assign forced = ~always_on_setting;
  // the cause bit pins the enable high so a failing system keeps resetting
  assign rst_en_eff = rst_en_reg | status_reg[wwrf_pkg::DOG_BIT] | forced;
  assign irq_en_eff = irq_en_reg & ~forced;
  assign unlocked = unlock_reg != 3'h0;
  // a rising edge is taken from the second and third synchroniser stages
  assign tick = osc_s2_reg & ~osc_s3_reg;
  assign wr_status = cpu_we & status_hit(cpu_addr, cpu_io_space);
  assign rd_status = cpu_re & status_hit(cpu_addr, cpu_io_space);
  assign wr_ctrl = cpu_we & ~cpu_io_space &
                   (cpu_addr == wwrf_pkg::CTRL_DATA_ADDR);
  assign rd_ctrl = cpu_re & ~cpu_io_space &
                   (cpu_addr == wwrf_pkg::CTRL_DATA_ADDR);
  assign any_reset = pin_reset_event | brownout_event | scan_reset_event |
                     sys_rst_reg;
  assign timeout = tick & (rst_en_eff | irq_en_eff) &
                   (cnt_reg + 1'b1 >= tmo_limit(tsel_reg));
  assign ctrl_view = {irq_flag_reg, irq_en_eff, tsel_reg[3], unlocked,
                      rst_en_eff, tsel_reg[2:0]};
  assign dog_irq_req = irq_flag_reg & irq_en_eff & cpu_global_irq_en;
  assign dog_sys_reset = sys_rst_reg;
  assign cpu_rdata = rdata_reg;

  always_comb begin
    status_next = status_reg;
    irq_flag_next = irq_flag_reg;
    irq_en_next = irq_en_reg;
    rst_en_next = rst_en_reg;
    tsel_next = tsel_reg;
    unlock_next = unlocked ? unlock_reg - 3'h1 : unlock_reg;
    cnt_next = cnt_reg;
    sys_rst_next = 1'b0;
    rdata_next = rdata_reg;

    if (rd_status) begin
      rdata_next = {3'h0, status_reg};
    end else if (rd_ctrl) begin
      rdata_next = ctrl_view;
    end

    // writing zero clears, writing one leaves a flag alone
    if (wr_status) begin
      status_next = status_reg & cpu_wdata[4:0];
    end

    if (wr_ctrl) begin
      if (cpu_wdata[wwrf_pkg::IRQ_FLAG_BIT]) begin
        irq_flag_next = 1'b0;
      end
      irq_en_next = cpu_wdata[wwrf_pkg::IRQ_EN_BIT];
      if (unlocked) begin
        rst_en_next = cpu_wdata[wwrf_pkg::RST_EN_BIT];
        tsel_next = {cpu_wdata[wwrf_pkg::TSEL_HI_BIT], cpu_wdata[2:0]};
      end else begin
        rst_en_next = rst_en_reg | cpu_wdata[wwrf_pkg::RST_EN_BIT];
      end
      if (cpu_wdata[wwrf_pkg::UNLOCK_BIT]) begin
        unlock_next = wwrf_pkg::UNLOCK_CYCLES;
      end
    end

    if (dog_vector_taken) begin
      irq_flag_next = 1'b0;
      if (rst_en_eff) begin
        irq_en_next = 1'b0;
      end
    end

    if (!(rst_en_eff | irq_en_eff)) begin
      cnt_next = '0;
    end else if (dog_kick) begin
      cnt_next = '0;
    end else if (timeout) begin
      cnt_next = '0;
    end else if (tick) begin
      cnt_next = cnt_reg + 1'b1;
    end

    // hardware sets after any clear above, so only the reset clear below can drop a set
    if (timeout) begin
      if (forced) begin
        sys_rst_next = 1'b1;
      end else if (irq_en_eff && rst_en_eff && irq_flag_reg) begin
        sys_rst_next = 1'b1;
      end else if (irq_en_eff) begin
        irq_flag_next = 1'b1;
      end else begin
        sys_rst_next = 1'b1;
      end
    end

    // a system reset reinitialises the control side, not the causes
    if (any_reset) begin
      irq_flag_next = 1'b0;
      irq_en_next = 1'b0;
      rst_en_next = 1'b0;
      tsel_next = 4'h0;
      unlock_next = 3'h0;
      cnt_next = '0;
    end
    if (sys_rst_reg) begin
      status_next[wwrf_pkg::DOG_BIT] = 1'b1;
    end
    if (pin_reset_event) begin
      status_next[wwrf_pkg::PIN_BIT] = 1'b1;
    end
    if (brownout_event) begin
      status_next[wwrf_pkg::BROWN_BIT] = 1'b1;
    end
    if (scan_reset_event) begin
      status_next[wwrf_pkg::SCAN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_reg <= wwrf_pkg::STATUS_RESET[4:0];
      irq_flag_reg <= wwrf_pkg::CTRL_RESET[wwrf_pkg::IRQ_FLAG_BIT];
      irq_en_reg <= wwrf_pkg::CTRL_RESET[wwrf_pkg::IRQ_EN_BIT];
      rst_en_reg <= wwrf_pkg::CTRL_RESET[wwrf_pkg::RST_EN_BIT];
      tsel_reg <= 4'h0;
      unlock_reg <= 3'h0;
      cnt_reg <= '0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      sys_rst_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
      irq_flag_reg <= irq_flag_next;
      irq_en_reg <= irq_en_next;
      rst_en_reg <= rst_en_next;
      tsel_reg <= tsel_next;
      unlock_reg <= unlock_next;
      cnt_reg <= cnt_next;
      osc_s1_reg <= wdt_osc;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      sys_rst_reg <= sys_rst_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/wwrf_pkg.sv
`default_nettype none
package wwrf_pkg;
  localparam logic [15:0] STATUS_DATA_ADDR = 16'h0054;
  localparam logic [15:0] IO_SPACE_SHIFT = 16'h0020;
  localparam logic [15:0] STATUS_IO_ADDR = STATUS_DATA_ADDR - IO_SPACE_SHIFT;
  localparam logic [15:0] CTRL_DATA_ADDR = 16'h0060;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // reset_cause_status bits
  localparam int SCAN_BIT = 4;
  localparam int DOG_BIT = 3;
  localparam int BROWN_BIT = 2;
  localparam int PIN_BIT = 1;
  localparam int POWER_BIT = 0;
  // watchdog_control_status bits
  localparam int IRQ_FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int TSEL_HI_BIT = 5;
  localparam int UNLOCK_BIT = 4;
  localparam int RST_EN_BIT = 3;
  // change window in system clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [3:0] TSEL_LAST = 4'h9;
  localparam int CNT_W = 21;
  // watchdog oscillator rate, for reference
  localparam int OSC_HZ = 128000;
endpackage
`default_nettype wire

// >>> tb/wwrf_checker.sv
`default_nettype none
module wwrf_checker #(parameter int BASE_CYCLES = 2048) (
  input wire logic ref_clk, rst_n, cpu_io_space, cpu_we, cpu_re,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata, cpu_rdata,
  input wire logic cpu_global_irq_en, dog_vector_taken, dog_kick,
  input wire logic always_on_setting, dog_irq_req, dog_sys_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctl_wr;
    cpu_we && !cpu_io_space && cpu_addr == 16'h0060;
  endsequence
  sequence s_ctl_rd;
    cpu_re && !cpu_io_space && cpu_addr == 16'h0060;
  endsequence
  chk_irq_gate: assert property (dog_irq_req |-> cpu_global_irq_en)
    else $error("irq request while globally masked");
  chk_vec_clear: assert property (dog_vector_taken |=> !dog_irq_req)
    else $error("irq request survives vector");
  chk_flag_wclr: assert property (s_ctl_wr ##0 cpu_wdata[7] |=> !dog_irq_req)
    else $error("irq request survives flag clear");
  chk_rst_pulse: assert property (dog_sys_reset |=> !dog_sys_reset [*8])
    else $error("system reset longer than one cycle");
  // a tick already in the pipe may still land, hence the skip of three
  chk_kick_quiet: assert property (dog_kick |-> ##3 !dog_sys_reset [*8])
    else $error("reset soon after kick");
  chk_rd_hold: assert property (!cpu_re |=> $stable(cpu_rdata))
    else $error("read data moved without a read");
  chk_io_ctl_void: assert property (cpu_re && cpu_io_space &&
    cpu_addr == 16'h0060 |=> $stable(cpu_rdata))
    else $error("control register answered io access");
  chk_aon_lock: assert property (s_ctl_rd ##0 !always_on_setting
    |=> !cpu_rdata[6] && cpu_rdata[3])
    else $error("always-on enables not locked");
endmodule
bind wwrf_top wwrf_checker #(.BASE_CYCLES(BASE_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .cpu_io_space(cpu_io_space),
  .cpu_we(cpu_we), .cpu_re(cpu_re), .cpu_addr(cpu_addr),
  .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .cpu_global_irq_en(cpu_global_irq_en), .dog_kick(dog_kick),
  .dog_vector_taken(dog_vector_taken), .dog_irq_req(dog_irq_req),
  .always_on_setting(always_on_setting), .dog_sys_reset(dog_sys_reset));
`default_nettype wire

// >>> tb/wwrf_cpu_model.sv
`default_nettype none
module wwrf_cpu_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic dog_irq_req,
  input wire logic svc_en,
  output logic dog_vector_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle vector entry, never two in a row before the flag drops
  always @(negedge ref_clk)
    dog_vector_taken <= rst_n && svc_en && dog_irq_req && !dog_vector_taken;
endmodule
`default_nettype wire

// >>> tb/wwrf_bench.sv
`default_nettype none
module wwrf_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b1, rst_n = 1'b0, io = 1'b0, we = 1'b0, re = 1'b0;
  logic gie = 1'b1, kick = 1'b0, aon = 1'b1, osc = 1'b0, svc = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00;
  wire logic [7:0] rd;
  wire logic irq, srst, vec;
  int err_total = 0, tests_run = 0, cyc = 0;
  wwrf_top #(.BASE_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .cpu_addr(addr), .cpu_io_space(io), .cpu_we(we), .cpu_re(re),
    .cpu_wdata(wd), .cpu_rdata(rd), .cpu_global_irq_en(gie),
    .dog_vector_taken(vec), .dog_kick(kick), .always_on_setting(aon),
    .wdt_osc(osc), .pin_reset_event(ev[0]), .brownout_event(ev[1]),
    .scan_reset_event(ev[2]), .dog_irq_req(irq), .dog_sys_reset(srst));
  wwrf_cpu_model CPU (.ref_clk(ref_clk), .rst_n(rst_n), .dog_irq_req(irq),
    .svc_en(svc), .dog_vector_taken(vec));
  initial forever #5 ref_clk = ~ref_clk;
  // free-running slow oscillator, phase unrelated to ref_clk
  initial begin
    #3;
    forever #40 osc = ~osc;
  end
  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {we, io, addr, wd} = {1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    we = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic i, input logic [7:0] e);
    @(negedge ref_clk);
    {re, io, addr} = {1'b1, i, a};
    @(negedge ref_clk);
    re = 1'b0;
    check(rd, e);
  endtask
  task automatic pulse_kick;
    @(negedge ref_clk);
    kick = 1'b1;
    @(negedge ref_clk);
    kick = 1'b0;
  endtask
  // sel 0 watches the irq request, 1 the system reset
  task automatic wait_hi(input bit sel, input int n, input logic e);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < n && !hit; k++) begin
      @(negedge ref_clk);
      hit = ((sel ? srst : irq) === 1'b1);
    end
    check({7'h00, hit}, {7'h00, e});
  endtask
  task automatic do_reset(input logic a);
    rst_n = 1'b0;
    aon = a;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
  endtask
  task automatic t_regs;
    rdc(16'h0054, 1'b0, 8'h01);
    rdc(16'h0034, 1'b1, 8'h01);
    rdc(16'h0060, 1'b1, 8'h01);
    rdc(16'h0060, 1'b0, 8'h00);
  endtask
  task automatic t_causes;
    logic [7:0] m[3] = '{8'h02, 8'h04, 8'h10};
    logic [7:0] acc = 8'h00;
    wr(16'h0054, 8'h00);
    rdc(16'h0054, 1'b0, 8'h00);
    for (int k = 0; k < 3; k++) begin
      @(negedge ref_clk);
      ev[k] = 1'b1;
      @(negedge ref_clk);
      ev[k] = 1'b0;
      acc = acc | m[k];
      rdc(16'h0054, 1'b0, acc);
    end
    wr(16'h0054, 8'h00);
    rdc(16'h0054, 1'b0, 8'h00);
  endtask
  task automatic t_irq;
    gie = 1'b0;
    wr(16'h0060, 8'h40);
    wait_hi(0, 100, 1'b0);
    rdc(16'h0060, 1'b0, 8'hC0);
    gie = 1'b1;
    wait_hi(0, 2, 1'b1);
    wr(16'h0060, 8'hC0);
    rdc(16'h0060, 1'b0, 8'h40);
    svc = 1'b1;
    wait_hi(0, 100, 1'b1);
    rdc(16'h0060, 1'b0, 8'h40);
    wr(16'h0060, 8'h80);
  endtask
  task automatic t_combined;
    pulse_kick();
    wr(16'h0060, 8'h48);
    wait_hi(0, 100, 1'b1);
    rdc(16'h0060, 1'b0, 8'h08);
    wait_hi(1, 100, 1'b1);
    rdc(16'h0054, 1'b0, 8'h08);
    rdc(16'h0060, 1'b0, 8'h08);
    svc = 1'b0;
    wr(16'h0060, 8'h48);
    wait_hi(0, 100, 1'b1);
    wait_hi(1, 100, 1'b1);
  endtask
  task automatic t_unlock;
    wr(16'h0054, 8'h00);
    rdc(16'h0060, 1'b0, 8'h00);
    pulse_kick();
    wr(16'h0060, 8'h1E);
    wr(16'h0060, 8'h0E);
    // the unlock bit still reads one in the last cycle of its window
    rdc(16'h0060, 1'b0, 8'h1E);
    wr(16'h0060, 8'h00);
    rdc(16'h0060, 1'b0, 8'h0E);
    wr(16'h0060, 8'h1E);
    repeat (6) @(negedge ref_clk);
    wr(16'h0060, 8'h00);
    rdc(16'h0060, 1'b0, 8'h0E);
    wr(16'h0060, 8'h1E);
    wr(16'h0060, 8'h00);
    rdc(16'h0060, 1'b0, 8'h10);
  endtask
  task automatic t_always_on;
    do_reset(1'b0);
    rdc(16'h0060, 1'b0, 8'h08);
    wr(16'h0060, 8'h40);
    rdc(16'h0060, 1'b0, 8'h08);
    repeat (5) begin
      pulse_kick();
      wait_hi(1, 20, 1'b0);
    end
    wait_hi(1, 100, 1'b1);
  endtask
  initial begin
    do_reset(1'b1);
    t_regs();
    t_causes();
    t_irq();
    t_combined();
    t_unlock();
    t_always_on();
    close_out();
  end
endmodule
`default_nettype wire
